// >>> core/swd_defs.svh
// Constants and register map of the watchdog unit behind the index and data ports.
`ifndef SWD_DEFS_SVH
`define SWD_DEFS_SVH
`define SWD_PORT_INDEX 16'h002E
`define SWD_PORT_DATA 16'h002F
`define SWD_UNLOCK_KEY 8'h87
`define SWD_LOCK_KEY 8'hAA
`define SWD_REG_LDN 8'h07
`define SWD_REG_ENABLE 8'h30
`define SWD_REG_ACTIVATE 8'hF0
`define SWD_REG_TBASE 8'hF5
`define SWD_REG_COUNT 8'hF6
`define SWD_LDN_WATCHDOG 8'h07
`define SWD_ENABLE_BIT 0
`define SWD_ACTIVATE_BIT 7
`define SWD_TBASE_MIN_BIT 3
`define SWD_TBASE_SEC 8'h71
`define SWD_TBASE_MIN 8'h79
`define SWD_ZERO8 8'h00
`define SWD_ONE8 8'h01
`define SWD_SEC_PER_MIN 6'h3B
`define SWD_CLK_PERIOD_NS 10
`define SWD_SECOND_NS 1000000000
`define SWD_RST_PULSE 5'h10
`endif

// >>> core/swd_pkg.sv
// Types shared by the watchdog unit.
package swd_pkg;
   // Gray-coded walk of the configuration lock.
   typedef enum logic [1:0] {
      SWD_LOCKED = 2'b00,
      SWD_HALF = 2'b01,
      SWD_OPEN = 2'b11
   } swd_lock_t;

   typedef struct packed {
      swd_lock_t lock;
      logic [7:0] index;
      logic [7:0] ldn;
      logic [7:0] enable;
      logic [7:0] activate;
      logic [7:0] tbase;
      logic [7:0] count;
      logic [31:0] presc;
      logic [5:0] minute;
      logic [4:0] rst_cnt;
      logic wd_reset;
      logic [7:0] rdata;
   } swd_state_t;
endpackage : swd_pkg

// >>> core/swd_watchdog.sv
// Watchdog unit of a super I/O controller, reached through the index and data ports.
`timescale 1ns/1ps
`default_nettype none
`include "swd_defs.svh"
module swd_watchdog #(
   parameter int unsigned SEC_CYCLES = `SWD_SECOND_NS / `SWD_CLK_PERIOD_NS
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire logic [15:0] io_addr,
   input wire logic io_wr,
   input wire logic io_rd,
   input wire logic [7:0] io_wdata,
   output logic [7:0] io_rdata,
   output logic wd_reset_out
);

   swd_pkg::swd_state_t s_q;
   swd_pkg::swd_state_t s_d;

   logic idx_wr;
   logic dat_wr;
   logic dat_rd;
   logic open;
   logic running;
   logic sec_tick;
   logic unit_tick;
   logic min_mode;
   logic count_wr;

   // True when the current index names a register of the watchdog device.
   function automatic logic wd_sel(input logic [7:0] ldn, input logic [7:0] idx, input logic [7:0] reg_idx);
      wd_sel = (ldn == `SWD_LDN_WATCHDOG) && (idx == reg_idx);
   endfunction : wd_sel

   assign idx_wr = io_wr && (io_addr == `SWD_PORT_INDEX);
   assign dat_wr = io_wr && (io_addr == `SWD_PORT_DATA);
   assign dat_rd = io_rd && (io_addr == `SWD_PORT_DATA);
   assign open = (s_q.lock == swd_pkg::SWD_OPEN);
   assign min_mode = s_q.tbase[`SWD_TBASE_MIN_BIT];
   assign running = s_q.enable[`SWD_ENABLE_BIT] && s_q.activate[`SWD_ACTIVATE_BIT] && (s_q.count != `SWD_ZERO8);
   assign sec_tick = running && (s_q.presc == SEC_CYCLES - 1);
   assign unit_tick = sec_tick && (!min_mode || (s_q.minute == `SWD_SEC_PER_MIN));
   assign count_wr = dat_wr && open && wd_sel(s_q.ldn, s_q.index, `SWD_REG_COUNT);

   always_comb begin
      s_d = s_q;
      // Two key writes to the index port open the ports; any other index write in between starts over.
      if (idx_wr) begin
         case (s_q.lock)
            swd_pkg::SWD_LOCKED: begin
               s_d.lock = (io_wdata == `SWD_UNLOCK_KEY) ? swd_pkg::SWD_HALF : swd_pkg::SWD_LOCKED;
            end
            swd_pkg::SWD_HALF: begin
               s_d.lock = (io_wdata == `SWD_UNLOCK_KEY) ? swd_pkg::SWD_OPEN : swd_pkg::SWD_LOCKED;
            end
            swd_pkg::SWD_OPEN: begin
               if (io_wdata == `SWD_LOCK_KEY) begin
                  s_d.lock = swd_pkg::SWD_LOCKED;
               end else begin
                  s_d.index = io_wdata;
               end
            end
            default: begin
               s_d.lock = swd_pkg::SWD_LOCKED;
            end
         endcase
      end
      // Prescaler runs only while the count is live, so a reload starts a full unit.
      if (running) begin
         if (sec_tick) begin
            s_d.presc = '0;
            s_d.minute = (s_q.minute == `SWD_SEC_PER_MIN) ? '0 : s_q.minute + 6'h01;
         end else begin
            s_d.presc = s_q.presc + 32'h00000001;
         end
      end else begin
         s_d.presc = '0;
         s_d.minute = '0;
      end
      if (unit_tick) begin
         s_d.count = s_q.count - `SWD_ONE8;
      end
      // A count reload in the expiry cycle wins, so the reset does not fire then.
      if (unit_tick && (s_q.count == `SWD_ONE8) && !count_wr) begin
         s_d.rst_cnt = `SWD_RST_PULSE;
      end else if (s_q.rst_cnt != '0) begin
         s_d.rst_cnt = s_q.rst_cnt - 5'h01;
      end
      s_d.wd_reset = (s_d.rst_cnt != '0);
      // Host writes come last so a reload beats an expiry in the same cycle.
      if (dat_wr && open) begin
         if (s_q.index == `SWD_REG_LDN) begin
            s_d.ldn = io_wdata;
         end
         if (wd_sel(s_q.ldn, s_q.index, `SWD_REG_ENABLE)) begin
            s_d.enable = io_wdata;
         end
         if (wd_sel(s_q.ldn, s_q.index, `SWD_REG_ACTIVATE)) begin
            s_d.activate = io_wdata;
         end
         if (wd_sel(s_q.ldn, s_q.index, `SWD_REG_TBASE)) begin
            s_d.tbase = io_wdata;
            s_d.presc = '0;
            s_d.minute = '0;
         end
         if (wd_sel(s_q.ldn, s_q.index, `SWD_REG_COUNT)) begin
            s_d.count = io_wdata;
            s_d.presc = '0;
            s_d.minute = '0;
         end
      end
      // Read data is captured one cycle after the strobe; a locked or unmapped read gives zero.
      if (io_rd) begin
         s_d.rdata = `SWD_ZERO8;
         if (io_addr == `SWD_PORT_INDEX && open) begin
            s_d.rdata = s_q.index;
         end else if (dat_rd && open) begin
            if (s_q.index == `SWD_REG_LDN) begin
               s_d.rdata = s_q.ldn;
            end else if (wd_sel(s_q.ldn, s_q.index, `SWD_REG_ENABLE)) begin
               s_d.rdata = s_q.enable;
            end else if (wd_sel(s_q.ldn, s_q.index, `SWD_REG_ACTIVATE)) begin
               s_d.rdata = s_q.activate;
            end else if (wd_sel(s_q.ldn, s_q.index, `SWD_REG_TBASE)) begin
               s_d.rdata = s_q.tbase;
            end else if (wd_sel(s_q.ldn, s_q.index, `SWD_REG_COUNT)) begin
               s_d.rdata = s_q.count;
            end
         end
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         s_q <= '0;
      end else if (clk_en) begin
         s_q <= s_d;
      end
   end

   assign io_rdata = s_q.rdata;
   assign wd_reset_out = s_q.wd_reset;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);

   // Configuration lock: two key writes open the ports and the lock key closes them.
   sequence key_wr;
      clk_en && idx_wr && (io_wdata == `SWD_UNLOCK_KEY);
   endsequence

   // Key, one idle bus cycle, key: the spacing that a plain host driver produces.
   sequence unlock_seq;
      (s_q.lock == swd_pkg::SWD_LOCKED) ##0 key_wr ##1 !(clk_en && idx_wr) ##1 key_wr;
   endsequence

   // Last unit of a live count with no reload racing it.
   sequence expire_evt;
      clk_en && unit_tick && (s_q.count == `SWD_ONE8) && !count_wr;
   endsequence

   AST_UNLOCK: assert property (unlock_seq |=> open)
      else $error("Two key writes did not open the configuration ports.");

   AST_HALF_OPEN: assert property ((s_q.lock == swd_pkg::SWD_HALF) ##0 key_wr |=> open)
      else $error("The second key write did not open the configuration ports.");

   AST_RELOCK: assert property (clk_en && idx_wr && open && (io_wdata == `SWD_LOCK_KEY) |=> !open)
      else $error("The lock key did not close the configuration ports.");

   AST_LOCKED_NO_WRITE: assert property (!open && clk_en && dat_wr
      |=> $stable(s_q.count) || $past(unit_tick))
      else $error("A locked data write changed the count.");

   AST_LOCKED_READ: assert property (clk_en && dat_rd && !open |=> io_rdata == `SWD_ZERO8)
      else $error("A locked data read returned nonzero data.");

   AST_INDEX_READ: assert property (clk_en && io_rd && (io_addr == `SWD_PORT_INDEX) && open
      |=> io_rdata == $past(s_q.index))
      else $error("An index port read did not return the index.");

   // Count behaviour: loading, gating by enable and by zero, and one step per unit.
   AST_LOAD: assert property (clk_en && count_wr |=> s_q.count == $past(io_wdata))
      else $error("Time value write did not load the count.");

   AST_ENABLE_GATE: assert property (clk_en && !s_q.enable[`SWD_ENABLE_BIT] && !count_wr
      |=> $stable(s_q.count))
      else $error("A disabled watchdog changed its count.");

   AST_ZERO_STAYS: assert property (s_q.count == `SWD_ZERO8 && !count_wr |=> s_q.count == `SWD_ZERO8)
      else $error("A zero time value started counting.");

   AST_ZERO_HOLD: assert property (s_q.count == `SWD_ZERO8 && !(dat_wr && open) |=> !$rose(wd_reset_out))
      else $error("A zero time value still produced a reset.");

   AST_SEC_STEP: assert property (clk_en && unit_tick && !count_wr
      |=> s_q.count == $past(s_q.count) - `SWD_ONE8)
      else $error("A finished unit did not take one off the count.");

   // The reset request must be long enough for the system to see it.
   AST_EXPIRE: assert property (expire_evt |=> wd_reset_out [*8])
      else $error("Countdown reached zero without a held system reset.");

   AST_PULSE_LEN: assert property ($fell(wd_reset_out) |-> $past(wd_reset_out, `SWD_RST_PULSE))
      else $error("The system reset request ended too early.");

   // Time base selection by the two documented codes.
   AST_SECONDS: assert property (clk_en && dat_wr && open && io_wdata == `SWD_TBASE_SEC
      && wd_sel(s_q.ldn, s_q.index, `SWD_REG_TBASE) |=> !min_mode)
      else $error("Writing the seconds code did not select seconds.");

   AST_MINUTES: assert property (clk_en && dat_wr && open && io_wdata == `SWD_TBASE_MIN
      && wd_sel(s_q.ldn, s_q.index, `SWD_REG_TBASE) |=> min_mode)
      else $error("Writing the minutes code did not select minutes.");

   AST_MIN_STEP: assert property (clk_en && sec_tick && min_mode && s_q.minute != `SWD_SEC_PER_MIN
      && !(dat_wr && open) |=> $stable(s_q.count))
      else $error("Minute mode decremented on a plain second.");

endmodule : swd_watchdog
`default_nettype wire

// >>> verification/swd_watchdog_tb.sv
// Self-checking testbench of the watchdog unit behind the index and data ports.
`timescale 1ns/1ps
`default_nettype none
`include "swd_defs.svh"
module superio_watchdog_timer_tb_top;
   // A short second keeps the minute case within a few hundred cycles.
   localparam int unsigned SEC = 10;
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic clk_en = 1'b1;
   logic [15:0] io_addr = 16'h0000;
   logic io_wr = 1'b0;
   logic io_rd = 1'b0;
   logic [7:0] io_wdata = 8'h00;
   logic [7:0] io_rdata;
   logic wd_reset_out;
   int n_mismatch = 0;
   int num_checks = 0;
   swd_watchdog #(.SEC_CYCLES(SEC)) swd_watchdog_inst (.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en),
      .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
      .wd_reset_out(wd_reset_out));
   initial begin
      forever #5 sys_clk = ~sys_clk;
   end
   task automatic tally_and_finish();
      $display("Checks %0d, mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : tally_and_finish
   task automatic chk8(string name, logic [7:0] exp, logic [7:0] got);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask : chk8
   task automatic chk1(string name, logic exp, logic got);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error %s expected %b seen %b", name, exp, got);
      end
   endtask : chk1
   task automatic io_write(logic [15:0] a, logic [7:0] d);
      @(posedge sys_clk);
      io_addr <= a;
      io_wdata <= d;
      io_wr <= 1'b1;
      @(posedge sys_clk);
      io_wr <= 1'b0;
   endtask : io_write
   task automatic reg_wr(logic [7:0] idx, logic [7:0] d);
      io_write(`SWD_PORT_INDEX, idx);
      io_write(`SWD_PORT_DATA, d);
   endtask : reg_wr
   task automatic port_chk(string name, logic [15:0] a, logic [7:0] exp);
      @(posedge sys_clk);
      io_addr <= a;
      io_rd <= 1'b1;
      @(posedge sys_clk);
      io_rd <= 1'b0;
      @(negedge sys_clk);
      chk8(name, exp, io_rdata);
   endtask : port_chk
   task automatic reg_chk(string name, logic [7:0] idx, logic [7:0] exp);
      io_write(`SWD_PORT_INDEX, idx);
      port_chk(name, `SWD_PORT_DATA, exp);
   endtask : reg_chk
   task automatic unlock_select();
      io_write(`SWD_PORT_INDEX, `SWD_UNLOCK_KEY);
      io_write(`SWD_PORT_INDEX, `SWD_UNLOCK_KEY);
      reg_wr(`SWD_REG_LDN, `SWD_LDN_WATCHDOG);
   endtask : unlock_select
   task automatic wait_low(int n, string name);
      logic seen = 1'b0;
      repeat (n) begin
         @(negedge sys_clk);
         if (wd_reset_out !== 1'b0) seen = 1'b1;
      end
      chk1(name, 1'b0, seen);
   endtask : wait_low
   // A missing pulse ends the run at once, as later scenarios would only cascade.
   task automatic expect_pulse(int lim);
      int i = 0;
      while (wd_reset_out !== 1'b1) begin
         @(negedge sys_clk);
         i++;
         if (i > lim) begin
            chk1("reset rise", 1'b1, 1'b0);
            tally_and_finish();
         end
      end
      repeat (16) begin
         chk1("reset pulse", 1'b1, wd_reset_out);
         @(negedge sys_clk);
      end
      chk1("reset end", 1'b0, wd_reset_out);
   endtask : expect_pulse
   task automatic sc_locked();
      io_write(16'h002D, `SWD_UNLOCK_KEY);
      io_write(16'h002D, `SWD_UNLOCK_KEY);
      reg_wr(`SWD_REG_COUNT, 8'h55);
      reg_chk("locked read", `SWD_REG_COUNT, 8'h00);
      unlock_select();
      reg_chk("count kept", `SWD_REG_COUNT, 8'h00);
      reg_chk("ldn", `SWD_REG_LDN, 8'h07);
      reg_wr(`SWD_REG_COUNT, 8'hFF);
      reg_chk("count max", `SWD_REG_COUNT, 8'hFF);
      reg_wr(`SWD_REG_COUNT, 8'h00);
      io_write(`SWD_PORT_INDEX, `SWD_LOCK_KEY);
      reg_chk("relocked", `SWD_REG_LDN, 8'h00);
   endtask : sc_locked
   task automatic sc_enable();
      unlock_select();
      reg_wr(`SWD_REG_ENABLE, 8'h01);
      reg_wr(`SWD_REG_ACTIVATE, 8'h80);
      reg_chk("enable", `SWD_REG_ENABLE, 8'h01);
      reg_chk("activate", `SWD_REG_ACTIVATE, 8'h80);
      port_chk("index port", `SWD_PORT_INDEX, `SWD_REG_ACTIVATE);
   endtask : sc_enable
   task automatic sc_seconds();
      reg_wr(`SWD_REG_COUNT, 8'h02);
      reg_wr(`SWD_REG_TBASE, `SWD_TBASE_SEC);
      wait_low(2 * SEC, "early seconds");
      expect_pulse(1);
      reg_chk("count after expiry", `SWD_REG_COUNT, 8'h00);
   endtask : sc_seconds
   task automatic sc_zero();
      reg_wr(`SWD_REG_COUNT, 8'h01);
      reg_wr(`SWD_REG_COUNT, 8'h00);
      wait_low(5 * SEC, "zero disables");
   endtask : sc_zero
   task automatic sc_reload();
      reg_wr(`SWD_REG_COUNT, 8'h03);
      repeat (4) begin
         wait_low(2 * SEC, "reloaded");
         reg_wr(`SWD_REG_COUNT, 8'h03);
      end
      reg_wr(`SWD_REG_COUNT, 8'h00);
   endtask : sc_reload
   task automatic sc_minutes();
      reg_wr(`SWD_REG_COUNT, 8'h01);
      reg_wr(`SWD_REG_TBASE, `SWD_TBASE_MIN);
      reg_chk("time base", `SWD_REG_TBASE, 8'h79);
      wait_low(60 * SEC - 5, "early minute");
      expect_pulse(1);
   endtask : sc_minutes
   // Twenty frozen cycles must push a one-second expiry back by exactly twenty cycles.
   task automatic sc_freeze();
      reg_wr(`SWD_REG_COUNT, 8'h01);
      @(posedge sys_clk);
      clk_en <= 1'b0;
      repeat (2 * SEC) @(posedge sys_clk);
      clk_en <= 1'b1;
      wait_low(SEC - 1, "frozen count");
      expect_pulse(1);
   endtask : sc_freeze
   task automatic sc_reset();
      reg_wr(`SWD_REG_COUNT, 8'h05);
      @(posedge sys_clk);
      sys_rst <= 1'b1;
      repeat (3) @(posedge sys_clk);
      sys_rst <= 1'b0;
      reg_chk("locked after reset", `SWD_REG_LDN, 8'h00);
      unlock_select();
      reg_chk("enable after reset", `SWD_REG_ENABLE, 8'h00);
      reg_chk("count after reset", `SWD_REG_COUNT, 8'h00);
   endtask : sc_reset
   initial begin
      repeat (12) @(posedge sys_clk);
      sys_rst <= 1'b0;
      sc_locked();
      sc_enable();
      sc_seconds();
      sc_zero();
      sc_reload();
      sc_freeze();
      sc_minutes();
      sc_reset();
      tally_and_finish();
   end
endmodule : superio_watchdog_timer_tb_top
`default_nettype wire
